// >>> hw/pipc_pkg.sv
// Purpose: shared constants and types of the picture-in-picture control register bank
// Assumes: 50 MHz ref_clk, synchronous active-low reset
// Notes: registers are 8 bit, reached only through the two-wire serial target port
//
// Behaviour
// R01: answer one of two target addresses, chosen by the address-select pin level.
// R02: accept sub-addresses 00H to 18H and 20H to 32H only.
// R03: host sends START, device address, one sub-address, then data bytes.
// R04: sub-address advances by one after each data byte until STOP.
// R05: host should write zero into bits without a function.
// R06: two bits in 00H enable main and sub picture independently.
// R07: a set hold bit stops that channel writing video into memory.
// R08: low nibble of 00H selects the layout from the fixed table.
// R09: single-field bit 0 reserves both fields; 1 shares one space.
// R10: single-field bit acts only while that channel's progressive bit is set.
// R11: host sets single-field where memory cannot hold a second field.
// R12: display progressive bit 1 reads one field; 0 uses both fields.
// R13: acquisition progressive bit 1 writes one field; 0 writes both fields.
// R14: filter bit turns on interpolation doubling 864 pixels per line.
// R15: on layout change, gray fill until channel updated unless fill disabled.
// R16: two reduced transfer modes: truncate to 6 bit, or smart reduction.
// R17: both reduction bits zero gives full 8-bit transfer.
// R18: host enables a reduction mode for full 672-pixel line layouts.
// R19: luma below threshold times 16 turns fast blanking off.
// R20: background horizontal offset moves whole display, 16 steps of 4 pixels.
// R21: background vertical offset moves whole display, 16 steps of 2 lines.
// R22: sub picture position, 256 steps of 4 pixels and 1 line.
// R23: background offset is a global offset, set once for centring.
// R24: registers hold values; effects apply from the next field boundary.
// R25: bytes to invalid sub-addresses are ignored but still acknowledged.
package pipc_pkg;

  // write form of the two target addresses; bit 0 is the direction bit
  localparam logic [7:0] PIPC_DEV_ADDR_LO = 8'h2c;
  localparam logic [7:0] PIPC_DEV_ADDR_HI = 8'h2e;

  localparam logic [7:0] PIPC_SA_PRIM_FIRST = 8'h00;
  localparam logic [7:0] PIPC_SA_PRIM_LAST = 8'h18;
  localparam logic [7:0] PIPC_SA_EXT_FIRST = 8'h20;
  localparam logic [7:0] PIPC_SA_EXT_LAST = 8'h32;

  localparam logic [7:0] PIP_ENABLE_FREEZE_MODE = 8'h00;
  localparam logic [7:0] FIELD_INTERLACE_CONTROL = 8'h01;
  localparam logic [7:0] DISPLAY_FILTER_TRANSFER_THRESHOLD = 8'h02;
  localparam logic [7:0] BACKGROUND_OFFSET = 8'h03;
  localparam logic [7:0] SUB_DISPLAY_HPOS = 8'h04;
  localparam logic [7:0] SUB_DISPLAY_VPOS = 8'h05;
  localparam logic [7:0] MAIN_DISPLAY_HPOS = 8'h06;
  localparam logic [7:0] MAIN_DISPLAY_VPOS = 8'h07;
  localparam logic [7:0] DISPLAY_REDUCTION = 8'h08;
  localparam logic [7:0] ACQUISITION_REDUCTION = 8'h09;
  localparam logic [7:0] ACQUISITION_HPOS = 8'h0a;
  localparam logic [7:0] SUB_ACQUISITION_VPOS = 8'h0b;
  localparam logic [7:0] MAIN_ACQUISITION_VPOS = 8'h0c;
  localparam logic [7:0] LIVE_PIP_SELECT = 8'h0d;
  localparam logic [7:0] HIGHLIGHT_BORDER_SELECT = 8'h0e;
  localparam logic [7:0] BORDER_SIZE = 8'h0f;
  localparam logic [7:0] SUB_BORDER_COLOUR = 8'h10;
  localparam logic [7:0] SUB_SELECT_BORDER_COLOUR = 8'h11;
  localparam logic [7:0] MAIN_BORDER_COLOUR = 8'h12;
  localparam logic [7:0] MAIN_SELECT_BORDER_COLOUR = 8'h13;
  localparam logic [7:0] BACKGROUND_COLOUR = 8'h14;
  localparam logic [7:0] SUB_DECODER_SETTINGS = 8'h15;
  localparam logic [7:0] MAIN_DECODER_SETTINGS = 8'h16;
  localparam logic [7:0] DISPLAY_SYNC_SETTINGS = 8'h17;
  localparam logic [7:0] CHROMA_PEDESTAL = 8'h18;

  localparam int PIPC_MEM_DEPTH = 64;
  localparam int PIPC_MEM_AW = 6;
  localparam logic [7:0] PIPC_REG_RESET = 8'h00;

  // display scaling: pixels or lines per offset step, and the luma threshold step, as shift amounts
  localparam int PIPC_BG_H_SHIFT = 2;
  localparam int PIPC_BG_V_SHIFT = 1;
  localparam int PIPC_SUB_H_SHIFT = 2;
  localparam int PIPC_LUMA_SHIFT = 4;

  typedef enum logic [2:0] {PIPC_ST_IDLE, PIPC_ST_ADDR, PIPC_ST_SUB, PIPC_ST_WDATA, PIPC_ST_RDATA} pipc_state_t;
  typedef enum logic [1:0] {PIPC_XFER_FULL8, PIPC_XFER_TRUNC6, PIPC_XFER_SMART} pipc_xfer_t;

  typedef struct packed {
    logic main_picture_enable;
    logic sub_picture_enable;
    logic main_hold_picture;
    logic sub_hold_picture;
    logic [3:0] layout_mode_field;
  } pipc_reg00_t;

  typedef struct packed {
    logic [1:0] spare_hi;
    logic main_single_field;
    logic sub_single_field;
    logic spare_mid;
    logic display_progressive;
    logic main_acq_progressive;
    logic sub_acq_progressive;
  } pipc_reg01_t;

  typedef struct packed {
    logic output_interp_filter;
    logic gray_fill_disable;
    logic smart_reduction;
    logic truncate_reduction;
    logic [3:0] luma_threshold;
  } pipc_reg02_t;

  typedef struct packed {
    logic [3:0] background_h_offset;
    logic [3:0] background_v_offset;
  } pipc_reg03_t;

  typedef struct packed {
    pipc_reg00_t r00;
    pipc_reg01_t r01;
    pipc_reg02_t r02;
    pipc_reg03_t r03;
    logic [7:0] sub_display_h_offset;
    logic [7:0] sub_display_v_offset;
  } pipc_ctrl_t;

endpackage

// >>> hw/pipc_sync.sv
// Purpose: two-flop synchroniser for pins from outside the ref_clk domain
// Assumes: inputs change slowly against ref_clk
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
module pipc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,              // system clock
  input wire logic resetn,               // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out      // levels safe to use in ref_clk logic
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      meta <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pipc_sync

// >>> hw/pipc_regmem.sv
// Purpose: byte store for every sub-address of the control bank
// Assumes: one write and one read port, same clock
// Notes: read data are registered, one cycle after the address
`timescale 1ns/1ps
module pipc_regmem
  import pipc_pkg::*;
(
  input wire logic ref_clk,                // system clock
  input wire logic resetn,                 // synchronous reset, active low
  input wire logic wr_en,                  // write strobe, one cycle
  input wire logic [PIPC_MEM_AW-1:0] wr_addr, // write index
  input wire logic [7:0] wr_data,          // write byte
  input wire logic [PIPC_MEM_AW-1:0] rd_addr, // read index
  output logic [7:0] rd_data               // registered read byte
);
  logic [7:0] mem [PIPC_MEM_DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < PIPC_MEM_DEPTH; i++)
        mem[i] <= PIPC_REG_RESET;
    end
    else if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rd_data <= PIPC_REG_RESET;
    else
      rd_data <= mem[rd_addr];
  end
endmodule // pipc_regmem

// >>> hw/pipc_bank.sv
// Purpose: serial-programmed control bank of the twin-channel picture-in-picture controller
// Assumes: scl, sda, address select and field sync are asynchronous pins
// Notes: settings written over the bus to 00H to 05H go live at the next field_sync rising edge
`timescale 1ns/1ps
module pipc_bank
  import pipc_pkg::*;
(
  input wire logic ref_clk,             // 50 MHz system clock
  input wire logic resetn,              // synchronous reset, active low
  input wire logic scl_i,               // serial clock pin level
  input wire logic sda_i,               // serial data pin level
  output logic sda_o,                   // serial data drive value, always low
  output logic sda_oe,                  // high while pulling sda low
  input wire logic addr_select_pin,     // picks the upper target address when high
  input wire logic field_sync,          // field boundary marker from video timing
  input wire logic main_updated,        // pulse: main channel written fresh picture
  input wire logic sub_updated,         // pulse: sub channel written fresh picture
  input wire logic [7:0] luma,          // current display luma, ref_clk domain
  output pipc_ctrl_t ctrl,              // live control settings
  output logic main_acq_write_en,       // main channel may write video memory
  output logic sub_acq_write_en,        // sub channel may write video memory
  output logic main_two_field_alloc,    // main channel reserves two field spaces
  output logic sub_two_field_alloc,     // sub channel reserves two field spaces
  output logic main_write_both_fields,  // main acquisition writes both fields
  output logic sub_write_both_fields,   // sub acquisition writes both fields
  output logic display_both_fields,     // display reads both fields
  output logic interp_filter_on,        // output runs at twice the 864 pixel rate
  output logic main_gray_fill,          // main pictures shown as 30% gray
  output logic sub_gray_fill,           // sub pictures shown as 30% gray
  output pipc_xfer_t xfer_mode,         // video memory transfer resolution
  output logic fast_blank_off,          // live background shows through
  output logic [5:0] bg_h_pixels,       // global horizontal shift in pixels
  output logic [4:0] bg_v_lines,        // global vertical shift in lines per field
  output logic [9:0] sub_h_pixels,      // sub picture horizontal place in pixels
  output logic [7:0] sub_v_lines        // sub picture vertical place in lines per field
);
  logic scl_s, sda_s, sel_s, fsync_s;
  logic scl_q, sda_q, fsync_q;
  logic scl_rise, scl_fall, start_det, stop_det, boundary;
  pipc_state_t state;
  logic [7:0] shreg, tx_shreg, sub_address, rd_data;
  logic [2:0] bit_cnt;
  logic byte_done, ack_phase, byte_evt;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] own_addr;
  logic sa_valid;
  pipc_ctrl_t pend, next_ctrl;

  pipc_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({scl_i, sda_i, addr_select_pin, field_sync}),
    .sync_out({scl_s, sda_s, sel_s, fsync_s})
  );

  pipc_regmem u_mem (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(wr_en),
    .wr_addr(wr_addr[PIPC_MEM_AW-1:0]),
    .wr_data(wr_data),
    .rd_addr(sub_address[PIPC_MEM_AW-1:0]),
    .rd_data(rd_data)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      fsync_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      fsync_q <= fsync_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  assign boundary = fsync_s && !fsync_q;
  assign byte_evt = scl_fall && byte_done;
  assign own_addr = sel_s ? PIPC_DEV_ADDR_HI : PIPC_DEV_ADDR_LO; // R01
  assign sa_valid = (sub_address <= PIPC_SA_PRIM_LAST)
                    || (sub_address >= PIPC_SA_EXT_FIRST && sub_address <= PIPC_SA_EXT_LAST); // R02
  assign sda_o = 1'b0;

  // bit shifting; start clears the count so a repeated start realigns the byte
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || start_det || stop_det)
    begin
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      shreg <= 8'h00;
    end
    else if (scl_rise && !ack_phase)
    begin
      shreg <= {shreg[6:0], sda_s};
      bit_cnt <= bit_cnt + 3'h1;
      byte_done <= (bit_cnt == 3'h7);
    end
    else if (byte_evt)
      byte_done <= 1'b0;
  end

  // protocol sequencing, acknowledge and read data drive
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || stop_det)
    begin
      state <= PIPC_ST_IDLE;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
      tx_shreg <= 8'h00;
    end
    else if (start_det)
    begin
      state <= PIPC_ST_ADDR; // R03
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (byte_evt)
    begin
      unique case (state)
        PIPC_ST_ADDR:
        begin
          if (shreg[7:1] == own_addr[7:1]) // R01
          begin
            ack_phase <= 1'b1;
            sda_oe <= 1'b1;
            state <= shreg[0] ? PIPC_ST_RDATA : PIPC_ST_SUB;
          end
          else
            state <= PIPC_ST_IDLE;
        end
        PIPC_ST_SUB:
        begin
          ack_phase <= 1'b1;
          sda_oe <= 1'b1;
          state <= PIPC_ST_WDATA;
        end
        PIPC_ST_WDATA:
        begin
          ack_phase <= 1'b1;
          sda_oe <= 1'b1; // R25
        end
        PIPC_ST_RDATA:
        begin
          ack_phase <= 1'b1;
          sda_oe <= 1'b0;
        end
        PIPC_ST_IDLE:
          sda_oe <= 1'b0;
      endcase
    end
    else if (scl_rise && ack_phase && state == PIPC_ST_RDATA && sda_s)
    begin
      state <= PIPC_ST_IDLE;
      ack_phase <= 1'b0;
    end
    else if (scl_fall && ack_phase)
    begin
      ack_phase <= 1'b0;
      if (state == PIPC_ST_RDATA)
      begin
        tx_shreg <= {rd_data[6:0], 1'b0};
        sda_oe <= !rd_data[7];
      end
      else
        sda_oe <= 1'b0;
    end
    else if (scl_fall && state == PIPC_ST_RDATA)
    begin
      tx_shreg <= {tx_shreg[6:0], 1'b0};
      sda_oe <= !tx_shreg[7];
    end
  end

  // sub-address pointer and register writes
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sub_address <= PIPC_SA_PRIM_FIRST;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (byte_evt && state == PIPC_ST_SUB)
        sub_address <= shreg;
      else if (byte_evt && state == PIPC_ST_WDATA)
      begin
        wr_en <= sa_valid; // R25
        wr_addr <= sub_address;
        wr_data <= shreg;
        sub_address <= sub_address + 8'h01; // R04
      end
      else if (byte_evt && state == PIPC_ST_RDATA)
        sub_address <= sub_address + 8'h01; // R04
    end
  end

  // pending copy of the live-effect registers, updated at once on a write
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      pend <= '0;
    else if (wr_en)
    begin
      unique case (wr_addr)
        PIP_ENABLE_FREEZE_MODE: pend.r00 <= wr_data; // R08
        FIELD_INTERLACE_CONTROL: pend.r01 <= wr_data;
        DISPLAY_FILTER_TRANSFER_THRESHOLD: pend.r02 <= wr_data;
        BACKGROUND_OFFSET: pend.r03 <= wr_data;
        SUB_DISPLAY_HPOS: pend.sub_display_h_offset <= wr_data;
        SUB_DISPLAY_VPOS: pend.sub_display_v_offset <= wr_data;
        default: pend <= pend;
      endcase
    end
  end

  // a write that lands in the boundary cycle is still taken at that edge
  always_comb
  begin
    next_ctrl = pend;
    if (wr_en)
    begin
      unique case (wr_addr)
        PIP_ENABLE_FREEZE_MODE: next_ctrl.r00 = wr_data;
        FIELD_INTERLACE_CONTROL: next_ctrl.r01 = wr_data;
        DISPLAY_FILTER_TRANSFER_THRESHOLD: next_ctrl.r02 = wr_data;
        BACKGROUND_OFFSET: next_ctrl.r03 = wr_data;
        SUB_DISPLAY_HPOS: next_ctrl.sub_display_h_offset = wr_data;
        SUB_DISPLAY_VPOS: next_ctrl.sub_display_v_offset = wr_data;
        default: next_ctrl = pend;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctrl <= '0;
    else if (boundary)
      ctrl <= next_ctrl; // R24
  end

  // gray fill: a layout change sets it, a fresh picture clears it, set wins
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      main_gray_fill <= 1'b0;
      sub_gray_fill <= 1'b0;
    end
    else if (boundary && next_ctrl.r00.layout_mode_field != ctrl.r00.layout_mode_field
             && !next_ctrl.r02.gray_fill_disable)
    begin
      main_gray_fill <= 1'b1; // R15
      sub_gray_fill <= 1'b1; // R15
    end
    else
    begin
      if (main_updated)
        main_gray_fill <= 1'b0;
      if (sub_updated)
        sub_gray_fill <= 1'b0;
    end
  end

  // decoded controls, all registered off the live settings
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      main_acq_write_en <= 1'b0;
      sub_acq_write_en <= 1'b0;
      main_two_field_alloc <= 1'b1;
      sub_two_field_alloc <= 1'b1;
      main_write_both_fields <= 1'b1;
      sub_write_both_fields <= 1'b1;
      display_both_fields <= 1'b1;
      interp_filter_on <= 1'b0;
      xfer_mode <= PIPC_XFER_FULL8;
      fast_blank_off <= 1'b0;
      bg_h_pixels <= 6'h00;
      bg_v_lines <= 5'h00;
      sub_h_pixels <= 10'h000;
      sub_v_lines <= 8'h00;
    end
    else
    begin
      main_acq_write_en <= ctrl.r00.main_picture_enable && !ctrl.r00.main_hold_picture; // R06 R07
      sub_acq_write_en <= ctrl.r00.sub_picture_enable && !ctrl.r00.sub_hold_picture; // R06 R07
      main_two_field_alloc <= !(ctrl.r01.main_single_field && ctrl.r01.main_acq_progressive); // R09 R10
      sub_two_field_alloc <= !(ctrl.r01.sub_single_field && ctrl.r01.sub_acq_progressive); // R09 R10
      main_write_both_fields <= !ctrl.r01.main_acq_progressive; // R13
      sub_write_both_fields <= !ctrl.r01.sub_acq_progressive; // R13
      display_both_fields <= !ctrl.r01.display_progressive; // R12
      interp_filter_on <= ctrl.r02.output_interp_filter; // R14
      // smart reduction wins if software sets both bits
      if (ctrl.r02.smart_reduction)
        xfer_mode <= PIPC_XFER_SMART; // R16
      else if (ctrl.r02.truncate_reduction)
        xfer_mode <= PIPC_XFER_TRUNC6; // R16
      else
        xfer_mode <= PIPC_XFER_FULL8; // R17
      fast_blank_off <= luma < ({4'h0, ctrl.r02.luma_threshold} << PIPC_LUMA_SHIFT); // R19
      bg_h_pixels <= {2'h0, ctrl.r03.background_h_offset} << PIPC_BG_H_SHIFT; // R20 R23
      bg_v_lines <= {1'h0, ctrl.r03.background_v_offset} << PIPC_BG_V_SHIFT; // R21 R23
      sub_h_pixels <= {2'h0, ctrl.sub_display_h_offset} << PIPC_SUB_H_SHIFT; // R22
      sub_v_lines <= ctrl.sub_display_v_offset; // R22
    end
  end

  sequence s_data_byte;
    byte_evt && state == PIPC_ST_WDATA;
  endsequence

  sequence s_layout_change;
    boundary && next_ctrl.r00.layout_mode_field != ctrl.r00.layout_mode_field && !next_ctrl.r02.gray_fill_disable;
  endsequence

  a_data_ack: assert property (@(posedge ref_clk) disable iff (!resetn) // R25
    s_data_byte ##1 !stop_det |-> sda_oe)
    else $error("data byte not acknowledged");

  a_sub_advance: assert property (@(posedge ref_clk) disable iff (!resetn) // R04
    s_data_byte |=> sub_address == $past(sub_address) + 8'h01)
    else $error("sub-address did not advance");

  a_range_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // R02
    s_data_byte ##1 wr_en |-> (wr_addr <= PIPC_SA_PRIM_LAST) || (wr_addr >= PIPC_SA_EXT_FIRST && wr_addr <= PIPC_SA_EXT_LAST))
    else $error("write to invalid sub-address");

  a_addr_reject: assert property (@(posedge ref_clk) disable iff (!resetn) // R01
    (byte_evt && state == PIPC_ST_ADDR && shreg[7:1] != own_addr[7:1] && !start_det && !stop_det)
    |=> state == PIPC_ST_IDLE && !sda_oe)
    else $error("foreign address acknowledged");

  a_live_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // R24
    !boundary |=> $stable(ctrl))
    else $error("settings changed outside field boundary");

  a_fill_set: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
    s_layout_change |=> main_gray_fill && sub_gray_fill)
    else $error("gray fill not set on layout change");

  a_freeze_stop: assert property (@(posedge ref_clk) disable iff (!resetn) // R07
    ctrl.r00.main_hold_picture ##1 ctrl.r00.main_hold_picture |-> !main_acq_write_en)
    else $error("frozen main channel still writing");

  a_single_field: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
    !ctrl.r01.sub_acq_progressive ##1 !ctrl.r01.sub_acq_progressive |-> sub_two_field_alloc)
    else $error("single field acted without progressive acquisition");

  a_full_xfer: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
    (!ctrl.r02.smart_reduction && !ctrl.r02.truncate_reduction) [*2] |-> xfer_mode == PIPC_XFER_FULL8)
    else $error("full resolution transfer not selected");

  a_luma_blank: assert property (@(posedge ref_clk) disable iff (!resetn) // R19
    $stable(ctrl) && luma < 8'h10 && ctrl.r02.luma_threshold != 4'h0 |=> fast_blank_off)
    else $error("fast blank not released for dark luma");
endmodule // pipc_bank

// >>> verif/pipc_host.sv
// Purpose: two-wire bus host model that programs the control bank
// Assumes: sda has a pull-up; scl period is 4*Q ref_clk cycles
// Notes: writes and single-byte reads; the host never stretches scl
`timescale 1ns/1ps
module pipc_host #(
  parameter int Q = 2
) (
  input wire logic ref_clk,  // system clock
  input wire logic sda_line, // resolved sda level
  output logic scl,          // serial clock
  output logic sda_low       // pulls sda low when high
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q;
    repeat (Q) @(posedge ref_clk);
  endtask
  // sda only moves a quarter period after scl falls, so it never looks like start or stop
  task automatic pulse(output logic lvl);
    q();
    scl <= 1'b1;
    q();
    lvl = sda_line;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic lvl;
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= !b[i];
      pulse(lvl);
    end
    sda_low <= 1'b0;
    pulse(lvl);
    ack = !lvl;
  endtask
  // a refused address still ends with stop, leaving the bus free
  task automatic xfer(input logic [7:0] dev, input logic [7:0] sa, input logic [47:0] d, input int n,
                      output logic [7:0] acks);
    logic a;
    acks = 8'h00;
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
    put(dev, a);
    acks[0] = a;
    for (int k = 0; k < n + 1 && a; k++)
    begin
      put(k == 0 ? sa : d[55-8*k -: 8], a);
      acks[k+1] = a;
    end
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // one byte from the current sub-address, closed by a not-acknowledge so the target lets go
  task automatic fetch(input logic [7:0] dev, output logic [7:0] v, output logic ack);
    logic lvl;
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
    put(dev | 8'h01, ack);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(lvl);
      v[i] = lvl;
    end
    pulse(lvl);
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
endmodule // pipc_host

// >>> verif/tb_pipc_bank.sv
// Purpose: self-checking bench of the picture-in-picture control bank
// Assumes: pipc_host drives the serial pins; field_sync is driven here
// Notes: expectations come from the bytes written, never from read-back
`timescale 1ns/1ps
module tb_pipc_bank
  import pipc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn, scl, sda_low, sda_o, sda_oe, addr_sel, fsync, m_upd, s_upd;
  logic mwe, swe, mtf, stf, mwb, swb, dboth, filt, mgray, sgray, fbo;
  logic [7:0] luma;
  logic [7:0] acks, rdv;
  logic rack;
  logic [7:0] subv;
  logic [5:0] bgh;
  logic [4:0] bgv;
  logic [9:0] subh;
  pipc_ctrl_t ctrl;
  pipc_xfer_t xfer_mode;
  logic [7:0] r2v [3] = '{8'h25, 8'h01, 8'h10};
  logic [7:0] lv [3] = '{8'h50, 8'h0f, 8'h00};
  logic [2:0] ev [3] = '{{1'b0, PIPC_XFER_SMART}, {1'b1, PIPC_XFER_FULL8}, {1'b0, PIPC_XFER_TRUNC6}};
  logic [7:0] av [4] = '{PIPC_DEV_ADDR_LO, PIPC_DEV_ADDR_HI, PIPC_DEV_ADDR_HI, PIPC_DEV_ADDR_LO};
  int fails = 0;
  int checks_done = 0;
  wire sda_line = !(sda_low || (sda_oe && !sda_o));
  wire [12:0] dec = {mwe, swe, mtf, stf, mwb, swb, dboth, filt, mgray, sgray, fbo, xfer_mode};
  always #10 ref_clk = !ref_clk;
  pipc_host host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  pipc_bank DUT (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_select_pin(addr_sel), .field_sync(fsync), .main_updated(m_upd),
    .sub_updated(s_upd), .luma(luma), .ctrl(ctrl), .main_acq_write_en(mwe), .sub_acq_write_en(swe),
    .main_two_field_alloc(mtf), .sub_two_field_alloc(stf), .main_write_both_fields(mwb),
    .sub_write_both_fields(swb), .display_both_fields(dboth), .interp_filter_on(filt),
    .main_gray_fill(mgray), .sub_gray_fill(sgray), .xfer_mode(xfer_mode), .fast_blank_off(fbo),
    .bg_h_pixels(bgh), .bg_v_lines(bgv), .sub_h_pixels(subh), .sub_v_lines(subv));
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // settings written over the bus only go live at a field boundary
  task automatic boundary;
    fsync <= 1'b1;
    repeat (6) @(posedge ref_clk);
    fsync <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    resetn = 1'b0;
    addr_sel = 1'b0;
    fsync = 1'b0;
    m_upd = 1'b0;
    s_upd = 1'b0;
    luma = 8'h4f;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(ctrl, 48'h0);
    chk(dec, 13'h7c0);
    host.xfer(PIPC_DEV_ADDR_LO, PIP_ENABLE_FREEZE_MODE, 48'hd3_26_95_73_ff_81, 6, acks);
    chk(acks, 8'hff);
    chk(ctrl, 48'h0);
    boundary();
    chk(ctrl, 48'hd3_26_95_73_ff_81);
    chk(dec, 13'h12bd);
    chk({bgh, bgv, subh, subv}, {6'h1c, 5'h06, 10'h3fc, 8'h81});
    m_upd <= 1'b1;
    @(posedge ref_clk);
    m_upd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({mgray, sgray}, 2'b01);
    for (int k = 0; k < 3; k++)
    begin
      luma <= lv[k];
      host.xfer(PIPC_DEV_ADDR_LO, DISPLAY_FILTER_TRANSFER_THRESHOLD, {r2v[k], 40'h0}, 1, acks);
      boundary();
      chk({fbo, xfer_mode}, ev[k]);
    end
    // the second data byte lands on an unused sub-address and must still be acked
    for (int k = 0; k < 4; k++)
    begin
      addr_sel <= k[1];
      repeat (4) @(posedge ref_clk);
      host.xfer(av[k], CHROMA_PEDESTAL, {16'h5a66, 32'h0}, 2, acks);
      chk(acks, k[0] ? 8'h00 : 8'h0f);
    end
    // hold the main channel only; the layout stays, so no gray fill may follow
    host.xfer(PIPC_DEV_ADDR_HI, PIP_ENABLE_FREEZE_MODE, {8'he3, 40'h0}, 1, acks);
    chk(acks, 8'h07);
    // the pointer now sits on 01H, which still holds the first session's byte
    host.fetch(PIPC_DEV_ADDR_HI, rdv, rack);
    chk({rack, rdv}, 9'h126);
    boundary();
    chk(ctrl, 48'he3_26_10_73_ff_81);
    chk({mwe, swe, mgray}, 3'b010);
    give_verdict();
  end
endmodule // tb_pipc_bank
